// ===== hw/rtc_regs_pkg.sv
// register map, field positions and timing constants for the clock flag block
package rtc_regs_pkg;

  localparam int          ADDR_W          = 17;
  localparam int          DATA_W          = 8;

  // register offsets
  localparam logic [16:0] FLAGS_OFS       = 17'h1fff0;
  localparam logic [16:0] CENTURY_OFS     = 17'h1fff1;
  localparam logic [16:0] ALM_SEC_OFS     = 17'h1fff2;
  localparam logic [16:0] ALM_MIN_OFS     = 17'h1fff3;
  localparam logic [16:0] ALM_HOUR_OFS    = 17'h1fff4;
  localparam logic [16:0] INT_STAT_OFS    = 17'h1ffe8;
  localparam logic [16:0] INT_MASK_OFS    = 17'h1ffe9;

  // flags register fields
  localparam int          WDOG_BIT        = 7;
  localparam int          ALARM_BIT       = 6;
  localparam int          PFAIL_BIT       = 5;
  localparam int          OSCILLATOR_FAIL_FLAG_BIT        = 4;
  localparam int          CAL_BIT         = 2;
  localparam int          FREEZE_BIT      = 1;
  localparam int          HOLD_BIT        = 0;

  // alarm field ignore bit
  localparam int          ALM_IGNORE_BIT  = 7;

  // interrupt status / mask fields
  localparam int          IRQ_N           = 4;
  localparam int          IRQ_WDOG        = 0;
  localparam int          IRQ_ALARM       = 1;
  localparam int          IRQ_PFAIL       = 2;
  localparam int          IRQ_OSCILLATOR_FAIL_FLAG        = 3;

  // reset values and BCD digit limit
  localparam logic [7:0]  CENTURY_RST     = 8'h00;
  localparam logic [7:0]  ALM_RST         = 8'h80;
  localparam logic [3:0]  INT_MASK_RST    = 4'h0;
  localparam logic [3:0]  BCD_MAX         = 4'h9;

  // timing
  localparam int          CLK_HZ          = 40_000_000;
  localparam int          SQ_WAVE_HZ      = 512;
  localparam int          SQ_HALF_CYC     = CLK_HZ / (2 * SQ_WAVE_HZ);

endpackage

// ===== hw/sq_wave_gen.sv
// divider that makes the calibration square wave from the reference clock
`timescale 1ns/1ps
module sq_wave_gen
  import rtc_regs_pkg::*;
#(
  parameter int HALF_CYC = SQ_HALF_CYC
)
(
  input  wire logic ref_clk,
  input  wire logic rst_b,
  input  wire logic run,
  output logic      wave
);

  logic [15:0] cnt_q;

  // counter restarts whenever the output is switched off, so each enable
  // begins with a full low half period
  always_ff @(posedge ref_clk or negedge rst_b)
  begin
    if (!rst_b)
    begin
      cnt_q <= 16'h0000;
      wave  <= 1'b0;
    end
    else if (!run)
    begin
      cnt_q <= 16'h0000;
      wave  <= 1'b0;
    end
    else if (cnt_q == 16'(HALF_CYC - 1))
    begin
      cnt_q <= 16'h0000;
      wave  <= ~wave;
    end
    else
    begin
      cnt_q <= cnt_q + 16'h0001;
    end
  end

endmodule

// ===== hw/rtc_flags_and_century_regs.sv
// century register, flag and control register, alarm masks and interrupt logic
`timescale 1ns/1ps
module rtc_flags_and_century_regs
  import rtc_regs_pkg::*;
#(
  parameter int SQ_HALF = SQ_HALF_CYC
)
(
  input  wire logic        ref_clk,
  input  wire logic        rst_b,
  input  wire logic        vbak_rst_b,
  input  wire logic [16:0] addr,
  input  wire logic [7:0]  wdata,
  input  wire logic        wr_stb,
  input  wire logic        rd_stb,
  output logic      [7:0]  rdata,
  input  wire logic [7:0]  cur_sec,
  input  wire logic [7:0]  cur_min,
  input  wire logic [7:0]  cur_hour,
  input  wire logic        sec_tick,
  input  wire logic        century_carry,
  input  wire logic        wdog_expire,
  input  wire logic        power_fail_pin,
  input  wire logic        osc_stop_pin,
  output logic             time_freeze,
  output logic             time_load,
  output logic             read_hold,
  output logic      [7:0]  century,
  output logic             irq,
  output logic             int_pin
);

  logic       cal_q;
  logic       freeze_q;
  logic       hold_q;
  logic       wdf_q;
  logic       af_q;
  logic       pf_q;
  logic       oscillator_fail_flag_q;
  logic [7:0] century_q;
  logic [7:0] shadow_q;
  logic [7:0] alm_sec_q;
  logic [7:0] alm_min_q;
  logic [7:0] alm_hour_q;
  logic [3:0] int_stat_q;
  logic [3:0] int_mask_q;
  logic [3:0] int_set;
  logic       load_q;
  logic       sq_wave;
  logic       alarm_match;
  logic       alarm_evt;
  logic       pf_evt;
  logic       osc_evt;
  logic       wr_flags;
  logic       rd_flags;
  logic [1:0] pin_raw;
  logic [1:0] pin_lvl_q;
  logic [1:0] pin_lvl_d1_q;

  // ---------------- decode helpers ----------------

  function automatic logic hit(input logic [16:0] a, input logic [16:0] ofs);
    hit = (a == ofs);
  endfunction

  // compare one alarm field unless its ignore bit is set
  function automatic logic field_ok(input logic [7:0] alm, input logic [7:0] cur);
    field_ok = alm[ALM_IGNORE_BIT] | (alm[6:0] == cur[6:0]);
  endfunction

  // clamp a written nibble so a stored digit never leaves 0..9
  function automatic logic [3:0] bcd_clamp(input logic [3:0] d);
    bcd_clamp = (d > BCD_MAX) ? BCD_MAX : d;
  endfunction

  assign wr_flags = wr_stb & hit(addr, FLAGS_OFS);
  assign rd_flags = rd_stb & hit(addr, FLAGS_OFS);

  // ---------------- pin input synchronisers ----------------

  assign pin_raw = {osc_stop_pin, power_fail_pin};

  // three stages; the filtered level moves only once stages two and three agree
  genvar gi;
  generate
    for (gi = 0; gi < 2; gi++)
    begin : g_sync
      logic s1_q;
      logic s2_q;
      logic s3_q;
      always_ff @(posedge ref_clk or negedge rst_b)
      begin
        if (!rst_b)
        begin
          s1_q          <= 1'b0;
          s2_q          <= 1'b0;
          s3_q          <= 1'b0;
          pin_lvl_q[gi] <= 1'b0;
        end
        else
        begin
          s1_q <= pin_raw[gi];
          s2_q <= s1_q;
          s3_q <= s2_q;
          if (s2_q == s3_q)
          begin
            pin_lvl_q[gi] <= s3_q;
          end
        end
      end
    end
  endgenerate

  always_ff @(posedge ref_clk or negedge rst_b)
  begin
    if (!rst_b)
    begin
      pin_lvl_d1_q <= 2'b00;
    end
    else
    begin
      pin_lvl_d1_q <= pin_lvl_q;
    end
  end

  assign pf_evt  = pin_lvl_q[0] & ~pin_lvl_d1_q[0];
  assign osc_evt = pin_lvl_q[1] & ~pin_lvl_d1_q[1];

  // ---------------- alarm compare ----------------

  assign alarm_match = field_ok(alm_sec_q, cur_sec) & field_ok(alm_min_q, cur_min)
                       & field_ok(alm_hour_q, cur_hour);
  assign alarm_evt   = sec_tick & alarm_match;

  always_ff @(posedge ref_clk or negedge rst_b)
  begin
    if (!rst_b)
    begin
      alm_sec_q  <= ALM_RST;
      alm_min_q  <= ALM_RST;
      alm_hour_q <= ALM_RST;
    end
    else if (wr_stb)
    begin
      if (hit(addr, ALM_SEC_OFS))
        alm_sec_q <= wdata;
      if (hit(addr, ALM_MIN_OFS))
        alm_min_q <= wdata;
      if (hit(addr, ALM_HOUR_OFS))
        alm_hour_q <= wdata;
    end
  end

  // ---------------- control bits of the flags register ----------------

  always_ff @(posedge ref_clk or negedge rst_b)
  begin
    if (!rst_b)
    begin
      cal_q    <= 1'b0;
      freeze_q <= 1'b0;
      hold_q   <= 1'b0;
    end
    else if (wr_flags)
    begin
      cal_q    <= wdata[CAL_BIT];
      freeze_q <= wdata[FREEZE_BIT];
      hold_q   <= wdata[HOLD_BIT];
    end
  end

  // ---------------- event flags: three cleared by reading flags, oscillator-fail cleared by writing zero ----------------

  // a new event in the reading cycle wins, so it is seen by the next read
  always_ff @(posedge ref_clk or negedge rst_b)
  begin
    if (!rst_b)
    begin
      wdf_q <= 1'b0;
      af_q  <= 1'b0;
      pf_q  <= 1'b0;
    end
    else
    begin
      wdf_q <= wdog_expire | (wdf_q & ~rd_flags);
      af_q  <= alarm_evt | (af_q & ~rd_flags);
      pf_q  <= pf_evt | (pf_q & ~rd_flags);
    end
  end

  // retained flag: only the backup-domain reset touches it, and a backup
  // power up means the time can no longer be trusted, so it comes up set
  always_ff @(posedge ref_clk or negedge vbak_rst_b)
  begin
    if (!vbak_rst_b)
    begin
      oscillator_fail_flag_q <= 1'b1;
    end
    else if (osc_evt)
    begin
      oscillator_fail_flag_q <= 1'b1;
    end
    else if (wr_flags && !wdata[OSCILLATOR_FAIL_FLAG_BIT])
    begin
      oscillator_fail_flag_q <= 1'b0;
    end
  end

  // ---------------- century register ----------------

  // writes stage in a shadow while frozen and reach the counter when freeze
  // drops; writes made while not frozen are ignored
  always_ff @(posedge ref_clk or negedge rst_b)
  begin
    if (!rst_b)
    begin
      shadow_q <= CENTURY_RST;
    end
    else if (wr_stb && hit(addr, CENTURY_OFS) && freeze_q)
    begin
      shadow_q <= {bcd_clamp(wdata[7:4]), bcd_clamp(wdata[3:0])};
    end
    else if (!freeze_q)
    begin
      shadow_q <= century_q;
    end
  end

  always_ff @(posedge ref_clk or negedge rst_b)
  begin
    if (!rst_b)
    begin
      century_q <= CENTURY_RST;
      load_q    <= 1'b0;
    end
    else
    begin
      load_q <= wr_flags & freeze_q & ~wdata[FREEZE_BIT];
      if (wr_flags && freeze_q && !wdata[FREEZE_BIT])
      begin
        century_q <= shadow_q;
      end
      else if (century_carry && !freeze_q)
      begin
        if (century_q[3:0] != BCD_MAX)
          century_q[3:0] <= century_q[3:0] + 4'h1;
        else
        begin
          century_q[3:0] <= 4'h0;
          century_q[7:4] <= (century_q[7:4] == BCD_MAX) ? 4'h0 : century_q[7:4] + 4'h1;
        end
      end
    end
  end

  // ---------------- interrupt status and mask ----------------

  always_comb
  begin
    int_set            = 4'h0;
    int_set[IRQ_WDOG]  = wdog_expire;
    int_set[IRQ_ALARM] = alarm_evt;
    int_set[IRQ_PFAIL] = pf_evt;
    int_set[IRQ_OSCILLATOR_FAIL_FLAG]  = osc_evt;
  end

  // write one to clear; an event in the same cycle keeps its bit set
  always_ff @(posedge ref_clk or negedge rst_b)
  begin
    if (!rst_b)
    begin
      int_stat_q <= 4'h0;
      int_mask_q <= INT_MASK_RST;
    end
    else
    begin
      if (wr_stb && hit(addr, INT_STAT_OFS))
        int_stat_q <= int_set | (int_stat_q & ~wdata[3:0]);
      else
        int_stat_q <= int_set | int_stat_q;
      if (wr_stb && hit(addr, INT_MASK_OFS))
        int_mask_q <= wdata[3:0];
    end
  end

  assign irq = |(int_stat_q & int_mask_q);

  // ---------------- calibration square wave and pin mux ----------------

  sq_wave_gen #(
    .HALF_CYC (SQ_HALF)
  ) u_sq (
    .ref_clk (ref_clk),
    .rst_b   (rst_b),
    .run     (cal_q),
    .wave    (sq_wave)
  );

  assign int_pin = cal_q ? sq_wave : irq;

  // ---------------- read port ----------------

  always_ff @(posedge ref_clk or negedge rst_b)
  begin
    if (!rst_b)
    begin
      rdata <= 8'h00;
    end
    else if (rd_stb)
    begin
      unique case (addr)
        FLAGS_OFS:    rdata <= {wdf_q, af_q, pf_q, oscillator_fail_flag_q, 1'b0, cal_q, freeze_q, hold_q};
        CENTURY_OFS:  rdata <= freeze_q ? shadow_q : century_q;
        ALM_SEC_OFS:  rdata <= alm_sec_q;
        ALM_MIN_OFS:  rdata <= alm_min_q;
        ALM_HOUR_OFS: rdata <= alm_hour_q;
        INT_STAT_OFS: rdata <= {4'h0, int_stat_q};
        INT_MASK_OFS: rdata <= {4'h0, int_mask_q};
        default:      rdata <= 8'h00;
      endcase
    end
    else
    begin
      rdata <= 8'h00;
    end
  end

  assign time_freeze = freeze_q;
  assign time_load   = load_q;
  assign read_hold   = hold_q;
  assign century     = century_q;

  // ---------------- assertions ----------------

  a_cal_wave_out: assert property (@(posedge ref_clk) disable iff (!rst_b)
    cal_q |-> int_pin == sq_wave)
    else $error("pin not carrying the square wave while calibrating");

  a_int_normal_mode: assert property (@(posedge ref_clk) disable iff (!rst_b)
    wr_flags && !wdata[CAL_BIT] |=> int_pin == irq)
    else $error("pin did not return to interrupt level");

  a_cal_reset_zero: assert property (@(posedge ref_clk)
    !$past(rst_b) |-> !cal_q)
    else $error("calibration bit not zero after reset");

  a_oscillator_fail_flag_sticky_hold: assert property (@(posedge ref_clk) disable iff (!vbak_rst_b)
    oscillator_fail_flag_q && !(wr_flags && !wdata[OSCILLATOR_FAIL_FLAG_BIT]) |=> oscillator_fail_flag_q)
    else $error("oscillator-fail flag cleared without a software write");

  a_oscillator_fail_flag_retained: assert property (@(posedge ref_clk) disable iff (!vbak_rst_b)
    !rst_b ##1 !rst_b |-> $stable(oscillator_fail_flag_q))
    else $error("oscillator-fail flag changed under main reset");

  a_freeze_load: assert property (@(posedge ref_clk) disable iff (!rst_b)
    $fell(freeze_q) |-> time_load && century_q == $past(shadow_q))
    else $error("written century not loaded when freeze dropped");

  a_frozen_stable: assert property (@(posedge ref_clk) disable iff (!rst_b)
    freeze_q && $past(freeze_q) |-> $stable(century_q))
    else $error("century changed while frozen");

  a_alarm_ignore: assert property (@(posedge ref_clk) disable iff (!rst_b)
    sec_tick && (&{alm_sec_q[7], alm_min_q[7], alm_hour_q[7]}) |=> af_q)
    else $error("alarm with every field ignored did not fire");

  a_alarm_compare: assert property (@(posedge ref_clk) disable iff (!rst_b)
    sec_tick && !alm_sec_q[7] && alm_sec_q[6:0] != cur_sec[6:0] && !wdog_expire
    |=> !int_stat_q[IRQ_ALARM] || $past(int_stat_q[IRQ_ALARM]))
    else $error("alarm fired on a compared field that differs");

  a_century_bcd: assert property (@(posedge ref_clk) disable iff (!rst_b)
    century_q[3:0] <= BCD_MAX && century_q[7:4] <= BCD_MAX)
    else $error("century digit outside 0 to 9");

endmodule

// ===== dv/host_bus_model.sv
// host side of the register port: one-cycle strobes, read data taken the cycle after
`timescale 1ns/1ps
module host_bus_model
(
  input  wire logic        ref_clk,
  output logic      [16:0] addr,
  output logic      [7:0]  wdata,
  output logic             wr_stb,
  output logic             rd_stb,
  input  wire logic [7:0]  rdata
);
  initial
  begin
    addr = 17'h00000;
    wdata = 8'h00;
    wr_stb = 1'b0;
    rd_stb = 1'b0;
  end

  task automatic wr(input logic [16:0] a, input logic [7:0] d);
    @(posedge ref_clk);
    addr <= a;
    wdata <= d;
    wr_stb <= 1'b1;
    @(posedge ref_clk);
    wr_stb <= 1'b0;
    // released data must not look like a still-valid value
    wdata <= ~d;
  endtask

  task automatic rd(input logic [16:0] a, output logic [7:0] d);
    @(posedge ref_clk);
    addr <= a;
    rd_stb <= 1'b1;
    @(posedge ref_clk);
    rd_stb <= 1'b0;
    #1;
    d = rdata;
  endtask
endmodule

// ===== dv/tb.sv
// self-checking bench for the clock flag and century registers
`timescale 1ns/1ps
module tb;
  import rtc_regs_pkg::*;
  localparam int HALF = 8;

  logic        ref_clk;
  logic        rst_b;
  logic        vbak_rst_b;
  logic [16:0] addr;
  logic [7:0]  wdata;
  logic        wr_stb;
  logic        rd_stb;
  logic [7:0]  rdata;
  logic [7:0]  cur_sec;
  logic        sec_tick;
  logic        wdog_expire;
  logic        time_freeze;
  logic        time_load;
  logic        read_hold;
  logic [7:0]  century;
  logic        irq;
  logic        int_pin;
  logic [7:0]  d;
  logic        v;
  int          n;
  int          mismatches;
  int          cmp_count;

  host_bus_model host (
    .ref_clk (ref_clk),
    .addr    (addr),
    .wdata   (wdata),
    .wr_stb  (wr_stb),
    .rd_stb  (rd_stb),
    .rdata   (rdata)
  );

  rtc_flags_and_century_regs #(.SQ_HALF(HALF)) dut (
    .ref_clk        (ref_clk),
    .rst_b          (rst_b),
    .vbak_rst_b     (vbak_rst_b),
    .addr           (addr),
    .wdata          (wdata),
    .wr_stb         (wr_stb),
    .rd_stb         (rd_stb),
    .rdata          (rdata),
    .cur_sec        (cur_sec),
    .cur_min        (8'h00),
    .cur_hour       (8'h00),
    .sec_tick       (sec_tick),
    .century_carry  (1'b0),
    .wdog_expire    (wdog_expire),
    .power_fail_pin (1'b0),
    .osc_stop_pin   (1'b0),
    .time_freeze    (time_freeze),
    .time_load      (time_load),
    .read_hold      (read_hold),
    .century        (century),
    .irq            (irq),
    .int_pin        (int_pin)
  );

  always #12.5 ref_clk = ~ref_clk;

  task automatic chk(input logic [7:0] got, input logic [7:0] exp);
    cmp_count++;
    if (got !== exp)
    begin
      mismatches++;
      $display("[ERR] t=%0t got=%h exp=%h", $time, got, exp);
    end
  endtask

  task automatic complete_run;
    $display("comparisons %0d mismatches %0d", cmp_count, mismatches);
    if (mismatches == 0 && cmp_count > 0)
      $display("DONE - PASS");
    else
      $display("DONE - FAIL");
    $finish;
  endtask

  task automatic pulse_wdog;
    @(posedge ref_clk);
    wdog_expire <= 1'b1;
    @(posedge ref_clk);
    wdog_expire <= 1'b0;
    repeat (2) @(posedge ref_clk);
    #1;
  endtask

  // one time-advance pulse, so the alarm comparison runs once
  task automatic tick_sec;
    @(posedge ref_clk);
    sec_tick <= 1'b1;
    @(posedge ref_clk);
    sec_tick <= 1'b0;
  endtask

  // the whole run is about a hundred cycles; this leaves a wide margin
  initial
  begin
    #100_000;
    mismatches++;
    complete_run();
  end

  initial
  begin
    ref_clk = 1'b0;
    rst_b = 1'b0;
    vbak_rst_b = 1'b0;
    cur_sec = 8'h00;
    sec_tick = 1'b0;
    wdog_expire = 1'b0;
    mismatches = 0;
    cmp_count = 0;
    repeat (8) @(posedge ref_clk);
    rst_b <= 1'b1;
    vbak_rst_b <= 1'b1;
    host.rd(FLAGS_OFS, d);
    chk(d, 8'h10);
    host.rd(17'h00010, d);
    chk(d, 8'h00);
    $display("test reset done");

    host.wr(FLAGS_OFS, 8'h10);
    host.rd(FLAGS_OFS, d);
    chk(d, 8'h10);
    @(posedge ref_clk);
    rst_b <= 1'b0;
    repeat (2) @(posedge ref_clk);
    rst_b <= 1'b1;
    host.rd(FLAGS_OFS, d);
    chk(d, 8'h10);
    host.wr(FLAGS_OFS, 8'h00);
    host.rd(FLAGS_OFS, d);
    chk(d, 8'h00);
    $display("test oscillator flag done");

    host.wr(CENTURY_OFS, 8'h42);
    host.rd(CENTURY_OFS, d);
    chk(d, 8'h00);
    host.wr(FLAGS_OFS, 8'h02);
    #1;
    chk({7'h00, time_freeze}, 8'h01);
    host.wr(CENTURY_OFS, 8'h3a);
    host.wr(FLAGS_OFS, 8'h00);
    #1;
    chk({7'h00, time_load}, 8'h01);
    chk(century, 8'h39);
    host.rd(CENTURY_OFS, d);
    chk(d, 8'h39);
    $display("test century done");

    host.wr(INT_MASK_OFS, 8'h00);
    pulse_wdog();
    chk({7'h00, irq}, 8'h00);
    host.rd(INT_STAT_OFS, d);
    chk(d, 8'h01);
    host.wr(INT_MASK_OFS, 8'h01);
    #1;
    chk({6'h00, irq, int_pin}, 8'h03);
    host.rd(FLAGS_OFS, d);
    chk(d, 8'h80);
    host.wr(INT_STAT_OFS, 8'h01);
    #1;
    chk({6'h00, irq, int_pin}, 8'h00);
    $display("test interrupt done");

    host.wr(FLAGS_OFS, 8'h04);
    @(negedge ref_clk);
    chk({7'h00, int_pin}, 8'h00);
    // measure one whole high phase, wherever the divider happens to start
    v = int_pin;
    for (n = 0; n < 20 && int_pin === v; n++) @(negedge ref_clk);
    v = int_pin;
    for (n = 0; n < 20 && int_pin === v; n++) @(negedge ref_clk);
    chk(8'(n), 8'(HALF));
    host.wr(FLAGS_OFS, 8'h00);
    repeat (2) @(negedge ref_clk);
    chk({7'h00, int_pin}, {7'h00, irq});
    chk({7'h00, int_pin}, 8'h00);
    host.wr(FLAGS_OFS, 8'h01);
    #1;
    chk({7'h00, read_hold}, 8'h01);
    host.wr(FLAGS_OFS, 8'h00);
    $display("test square wave done");

    cur_sec <= 8'h15;
    host.wr(ALM_SEC_OFS, 8'h15);
    tick_sec();
    host.rd(FLAGS_OFS, d);
    chk(d, 8'h40);
    host.wr(ALM_SEC_OFS, 8'h95);
    host.wr(ALM_MIN_OFS, 8'h07);
    tick_sec();
    host.rd(FLAGS_OFS, d);
    chk(d, 8'h00);
    // every field ignored: the alarm must fire on any tick
    host.wr(ALM_MIN_OFS, 8'h80);
    tick_sec();
    host.rd(FLAGS_OFS, d);
    chk(d, 8'h40);
    // compared seconds field differs: no alarm, status stays clear
    host.wr(INT_STAT_OFS, 8'h02);
    host.wr(ALM_SEC_OFS, 8'h14);
    tick_sec();
    host.rd(FLAGS_OFS, d);
    chk(d, 8'h00);
    host.rd(INT_STAT_OFS, d);
    chk(d, 8'h00);
    $display("test alarm done");
    complete_run();
  end
endmodule
